// File: design/asu_pkg.sv
// package: memory map constants and carrier types for the address select unit
package asu_pkg;
	localparam int ASU_AW          = 32;
	localparam int ASU_NREG        = 4;   // programmable memory regions
	localparam int ASU_NPERIPH     = 13;  // control-loop peripheral windows
	// region indices
	localparam int ASU_R_PFLASH    = 0;
	localparam int ASU_R_ROM       = 1;
	localparam int ASU_R_DFLASH    = 2;
	localparam int ASU_R_RAM       = 3;
	// size codes: window = 1 kB << code, 0 = 1 kB ... 14 = 16 MB
	localparam int ASU_SZ_LSB      = 10;
	localparam logic [3:0] ASU_SZ_MAX = 4'he;
	// reset map
	localparam logic [31:0] ASU_RST_PF_BASE  = 32'h0001_0000;
	localparam logic [3:0]  ASU_RST_PF_SZ    = 4'h5;  // 32 kB
	localparam logic [31:0] ASU_RST_ROM_BASE = 32'h0000_0000;
	localparam logic [3:0]  ASU_RST_ROM_SZ   = 4'h6;  // 64 kB, 16 aliases
	localparam logic [31:0] ASU_DF_BASE      = 32'h0001_8800;
	localparam logic [3:0]  ASU_DF_SZ        = 4'h1;  // 2 kB
	localparam logic [31:0] ASU_RAM_BASE     = 32'h0001_9000;
	localparam logic [3:0]  ASU_RAM_SZ       = 4'h2;  // 4 kB
	// normal map preset
	localparam logic [31:0] ASU_NRM_PF_BASE  = 32'h0000_0000;
	localparam logic [31:0] ASU_NRM_ROM_BASE = 32'h0001_0000;
	localparam logic [3:0]  ASU_NRM_ROM_SZ   = 4'h2;  // 4 kB
	// peripheral windows: 0x0002_0000 + n * 0x1_0000, 256 bytes each
	localparam logic [3:0]  ASU_PER_FIRST    = 4'h2;
	localparam logic [3:0]  ASU_PER_LAST     = 4'he;
	// own register window and offsets inside it
	localparam logic [23:0] ASU_OWN_BASE     = 24'hFF_FFFE;  // addr[31:8]
	localparam logic [7:0]  ASU_OFF_CTRL     = 8'h00;
	localparam logic [7:0]  ASU_OFF_RBASE    = 8'h10;  // + 8 * region
	localparam logic [7:0]  ASU_OFF_RSIZE    = 8'h14;  // + 8 * region
	localparam int          ASU_CTRL_NORMAL  = 0;
	// select lines toward memories and peripherals
	typedef struct packed {
		logic                   boot_rom;
		logic                   prog_flash;
		logic                   data_flash;
		logic                   data_ram;
		logic                   own_regs;
		logic [ASU_NPERIPH-1:0] periph;
	} asu_sel_t;
	// location inside the selected memory
	typedef struct packed {
		logic [12:0] word_addr;  // 32-bit word index
		logic [4:0]  pf_page;    // 1 kB program flash page
		logic [5:0]  df_page;    // 32 byte data flash page
	} asu_loc_t;
endpackage : asu_pkg

// File: design/asu_address_select_unit.sv
// address_select_unit: processor bus decoder with reset and normal memory maps
// Functional notes
// (RQ1) After reset the boot ROM covers the lowest 64K and program flash sits at 0x0001_0000-0x0001_7FFF.
// (RQ2) In the reset map the 4K boot ROM repeats sixteen times across the low 64K.
// (RQ3) Once reconfigured, program flash sits at address zero and the boot ROM moves to 0x0001_0000.
// (RQ4) Data flash answers at 0x0001_8800-0x0001_8FFF in both maps, 512 words in 32-byte pages.
// (RQ5) Data RAM answers at 0x0001_9000-0x0001_9FFF in both maps as 1K words.
// (RQ6) Program flash is 8K words with 1kB page erase and whole-array mass erase.
// (RQ7) Every target hangs off one bus at its own non-overlapping span.
// (RQ8) Control-loop peripherals get 256-byte windows from 0x0002_0000 to 0x000E_0000 in 0x1_0000 steps.
// (RQ9) The boot ROM runs first after power-up and hands over to flash only on a valid program. Code remaps on any privileged CTRL write of bit 0.
// (RQ10) Any access to the decoder's own registers costs the processor one wait state.
// (RQ11) The decoder's own registers take writes only in privileged mode.
// (RQ12) Each memory select window is sized by register from 1 kB to 16 MB.
// (RQ13) An address outside every mapped window raises no select.
module asu_address_select_unit
	import asu_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// processor access
	input  wire logic        cpu_req,
	input  wire logic [31:0] cpu_addr,
	input  wire logic        cpu_write,
	input  wire logic [31:0] cpu_wdata,
	input  wire logic        cpu_priv,
	output logic             cpu_wait,
	output logic [31:0]      cpu_rdata,
	// decode results
	output asu_sel_t         sel,
	output asu_loc_t         loc,
	output logic             unmapped,
	output logic             map_normal
);
	////////////////////////////////////////////////////////////////////////
	logic [31:0] base_reg [ASU_NREG];
	logic [3:0]  size_reg [ASU_NREG];
	logic        normal_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;
	logic        own_hit;
	logic        own_go;     // second cycle of an own-register access
	logic        own_wr;
	logic [ASU_NREG-1:0] hit;
	logic [3:0]  per_idx;
	logic        per_ok;

	// window match, base taken as aligned to the window size
	function automatic logic win_hit(input logic [31:0] a,
		input logic [31:0] b, input logic [3:0] code);
		logic [31:0] mask;
		mask = 32'hFFFF_FFFF << (ASU_SZ_LSB + int'(code));
		return ((a ^ b) & mask) == 32'h0000_0000;
	endfunction : win_hit

	////////////////////////////////////////////////////////////////////////
	// region and peripheral decode
	assign own_hit = cpu_addr[31:8] == ASU_OWN_BASE;
	assign per_idx = cpu_addr[19:16];
	assign per_ok  = cpu_addr[31:20] == 12'h000 && cpu_addr[15:8] == 8'h00
		&& per_idx >= ASU_PER_FIRST && per_idx <= ASU_PER_LAST;  // [RQ8]
	always_comb begin
		for (int i = 0; i < ASU_NREG; i++) begin
			hit[i] = win_hit(cpu_addr, base_reg[i], size_reg[i]);  // [RQ12]
		end
	end

	// fixed priority keeps selects one-hot if firmware overlaps windows
	always_comb begin
		sel = '0;
		if (cpu_req) begin
			if (own_hit) begin
				sel.own_regs = 1'b1;
			end else if (per_ok) begin
				sel.periph[per_idx - ASU_PER_FIRST] = 1'b1;  // [RQ8]
			end else if (hit[ASU_R_DFLASH]) begin
				sel.data_flash = 1'b1;  // [RQ4]
			end else if (hit[ASU_R_RAM]) begin
				sel.data_ram = 1'b1;  // [RQ5]
			end else if (hit[ASU_R_PFLASH]) begin
				sel.prog_flash = 1'b1;  // [RQ1] [RQ3]
			end else if (hit[ASU_R_ROM]) begin
				sel.boot_rom = 1'b1;  // [RQ1] [RQ9]
			end
		end
	end
	assign unmapped = cpu_req && sel == '0;  // [RQ13] [RQ7]

	// offset inside the target; ROM drops bits above 4K so it aliases
	always_comb begin
		loc           = '0;
		loc.pf_page   = cpu_addr[14:10];  // [RQ6]
		loc.df_page   = cpu_addr[10:5];   // [RQ4]
		if (sel.boot_rom) begin
			loc.word_addr = {3'b000, cpu_addr[11:2]};  // [RQ2]
		end else if (sel.prog_flash) begin
			loc.word_addr = cpu_addr[14:2];  // [RQ6]
		end else if (sel.data_flash) begin
			loc.word_addr = {4'h0, cpu_addr[10:2]};  // [RQ4]
		end else if (sel.data_ram) begin
			loc.word_addr = {3'b000, cpu_addr[11:2]};  // [RQ5]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one wait state on own-register access, completion in second cycle
	assign cpu_wait = cpu_req && own_hit && !wait_reg;  // [RQ10]
	assign own_go   = cpu_req && own_hit && wait_reg;
	assign own_wr   = own_go && cpu_write && cpu_priv;  // [RQ11]
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= cpu_wait;  // [RQ10]
		end
	end

	// map registers; reset values give the boot map
	always_ff @(posedge clk) begin
		if (srst) begin
			base_reg[ASU_R_PFLASH] <= ASU_RST_PF_BASE;   // [RQ1]
			size_reg[ASU_R_PFLASH] <= ASU_RST_PF_SZ;
			base_reg[ASU_R_ROM]    <= ASU_RST_ROM_BASE;  // [RQ9]
			size_reg[ASU_R_ROM]    <= ASU_RST_ROM_SZ;    // [RQ2]
			base_reg[ASU_R_DFLASH] <= ASU_DF_BASE;
			size_reg[ASU_R_DFLASH] <= ASU_DF_SZ;
			base_reg[ASU_R_RAM]    <= ASU_RAM_BASE;
			size_reg[ASU_R_RAM]    <= ASU_RAM_SZ;
			normal_reg             <= 1'b0;
		end else if (own_wr) begin
			if (cpu_addr[7:0] == ASU_OFF_CTRL
				&& cpu_wdata[ASU_CTRL_NORMAL]) begin
				// one write loads the whole normal map preset
				base_reg[ASU_R_PFLASH] <= ASU_NRM_PF_BASE;   // [RQ3]
				base_reg[ASU_R_ROM]    <= ASU_NRM_ROM_BASE;  // [RQ3]
				size_reg[ASU_R_ROM]    <= ASU_NRM_ROM_SZ;
				normal_reg             <= 1'b1;
			end
			for (int i = 0; i < ASU_NREG; i++) begin
				if (cpu_addr[7:0] == ASU_OFF_RBASE + 8'(8 * i)) begin
					base_reg[i] <= cpu_wdata;
				end
				// codes above 16 MB clamp to the largest window
				if (cpu_addr[7:0] == ASU_OFF_RSIZE + 8'(8 * i)) begin
					size_reg[i] <= (cpu_wdata[3:0] > ASU_SZ_MAX)
						? ASU_SZ_MAX : cpu_wdata[3:0];  // [RQ12]
				end
			end
		end
	end

	// read data captured in the wait cycle, valid when wait drops
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (cpu_wait) begin
			rdata_reg <= 32'h0000_0000;
			if (cpu_addr[7:0] == ASU_OFF_CTRL) begin
				rdata_reg <= {31'h0000_0000, normal_reg};
			end
			for (int i = 0; i < ASU_NREG; i++) begin
				if (cpu_addr[7:0] == ASU_OFF_RBASE + 8'(8 * i)) begin
					rdata_reg <= base_reg[i];
				end
				if (cpu_addr[7:0] == ASU_OFF_RSIZE + 8'(8 * i)) begin
					rdata_reg <= {28'h000_0000, size_reg[i]};
				end
			end
		end
	end
	assign cpu_rdata  = rdata_reg;
	assign map_normal = normal_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_own_first;
		cpu_req && own_hit && !wait_reg;
	endsequence
	sequence s_remap;
		s_own_first ##1 (own_wr && cpu_addr[7:0] == ASU_OFF_CTRL
			&& cpu_wdata[ASU_CTRL_NORMAL]);
	endsequence

	property p_reset_map;
		@(posedge clk) $past(srst) && !srst |-> !normal_reg
			&& base_reg[ASU_R_ROM] == ASU_RST_ROM_BASE
			&& size_reg[ASU_R_ROM] == ASU_RST_ROM_SZ
			&& base_reg[ASU_R_PFLASH] == ASU_RST_PF_BASE;
	endproperty
	a_reset_map: assert property (p_reset_map)  // [RQ1] [RQ9]
		else $error("reset map not applied");

	property p_rom_alias;
		@(posedge clk) disable iff (srst)
		sel.boot_rom |-> loc.word_addr == {3'b000, cpu_addr[11:2]};
	endproperty
	a_rom_alias: assert property (p_rom_alias)  // [RQ2]
		else $error("boot rom offset does not alias on 4K");

	property p_remap;
		@(posedge clk) disable iff (srst)
		s_remap |=> normal_reg && base_reg[ASU_R_PFLASH] == 32'h0000_0000
			&& base_reg[ASU_R_ROM] == 32'h0001_0000;
	endproperty
	a_remap: assert property (p_remap)  // [RQ3]
		else $error("normal map not loaded");

	property p_dflash;
		@(posedge clk) disable iff (srst)
		cpu_req && cpu_addr >= 32'h0001_8800 && cpu_addr <= 32'h0001_8FFF
			&& base_reg[ASU_R_DFLASH] == ASU_DF_BASE
			&& size_reg[ASU_R_DFLASH] == ASU_DF_SZ
			|-> sel.data_flash && loc.df_page == cpu_addr[10:5];
	endproperty
	a_dflash: assert property (p_dflash)  // [RQ4]
		else $error("data flash not selected");

	property p_ram;
		@(posedge clk) disable iff (srst)
		cpu_req && cpu_addr[31:12] == 20'h0001_9
			&& base_reg[ASU_R_RAM] == ASU_RAM_BASE
			&& size_reg[ASU_R_RAM] == ASU_RAM_SZ |-> sel.data_ram;
	endproperty
	a_ram: assert property (p_ram)  // [RQ5]
		else $error("data ram not selected");

	property p_onehot;
		@(posedge clk) disable iff (srst)
		$onehot0(sel) && (unmapped == (cpu_req && sel == '0));
	endproperty
	a_onehot: assert property (p_onehot)  // [RQ7] [RQ13]
		else $error("selects overlap or unmapped wrong");

	property p_periph;
		@(posedge clk) disable iff (srst)
		cpu_req && cpu_addr[31:8] == 24'h00_0A00 |-> sel.periph[8];
	endproperty
	a_periph: assert property (p_periph)  // [RQ8]
		else $error("peripheral window not selected");

	property p_wait;
		@(posedge clk) disable iff (srst)
		s_own_first |-> cpu_wait ##1 (!cpu_wait || !cpu_req);
	endproperty
	a_wait: assert property (p_wait)  // [RQ10]
		else $error("own access wait state wrong");

	property p_user_wr;
		@(posedge clk) disable iff (srst)
		own_go && cpu_write && !cpu_priv |=> $stable(normal_reg)
			&& $stable(base_reg[ASU_R_PFLASH]) && $stable(size_reg[ASU_R_ROM]);
	endproperty
	a_user_wr: assert property (p_user_wr)  // [RQ11]
		else $error("user mode write changed map");

	property p_size_max;
		@(posedge clk) disable iff (srst)
		size_reg[ASU_R_PFLASH] <= ASU_SZ_MAX && size_reg[ASU_R_RAM] <= ASU_SZ_MAX;
	endproperty
	a_size_max: assert property (p_size_max)  // [RQ12]
		else $error("window size above 16 MB");
endmodule : asu_address_select_unit

// File: tb/asu_cpu_model.sv
// processor-side access model for the address select unit request port
module asu_cpu_model (
	// clock
	input  wire logic        clk,
	// request toward the decoder
	output logic             cpu_req,
	output logic [31:0]      cpu_addr,
	output logic             cpu_write,
	output logic [31:0]      cpu_wdata,
	output logic             cpu_priv,
	// answer from the decoder
	input  wire logic        cpu_wait,
	input  wire logic [31:0] cpu_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet bus from time zero
	initial begin
		cpu_req   = 1'b0;
		cpu_addr  = 32'h0000_0000;
		cpu_write = 1'b0;
		cpu_wdata = 32'h0000_0000;
		cpu_priv  = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// launch a request after a falling edge
	task automatic start(logic [31:0] a, logic wr, logic [31:0] wd, logic pr);
		@(negedge clk);
		cpu_req   = 1'b1;
		cpu_addr  = a;
		cpu_write = wr;
		cpu_wdata = wd;
		cpu_priv  = pr;
	endtask : start
	// hold until wait drops, bounded so a stuck wait cannot hang the run
	task automatic finish(output logic [31:0] rd, output int n);
		n = 0;
		while (cpu_wait !== 1'b0 && n < 8) begin
			n++;
			@(negedge clk);
		end
		rd = cpu_rdata;
		@(posedge clk);
		#1;
	endtask : finish
	// address and write data flip on release so the decoder cannot lean on stale values
	task automatic idle();
		@(negedge clk);
		cpu_req   = 1'b0;
		cpu_addr  = ~cpu_addr;
		cpu_wdata = ~cpu_wdata;
	endtask : idle
endmodule : asu_cpu_model

// File: tb/tb_memory_map_decoder.sv
// bench: random and corner decode checks for the address select unit
module tb_memory_map_decoder
	import asu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        cpu_req, cpu_write, cpu_priv, cpu_wait, unmapped, map_normal;
	logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, rd, a;
	asu_sel_t    sel;
	asu_loc_t    loc;
	int          fails = 0;
	int          cmp_count = 0;
	int          w;
	logic [31:0] rng = 32'h0001_7C6A;  // seed 97386
	logic [31:0] cor [16] = '{32'h0000_0000, 32'h0000_F004, 32'h0001_0000,
		32'h0001_7FFC, 32'h0001_8000, 32'h0001_87FC, 32'h0001_8800,
		32'h0001_8FFC, 32'h0001_9000, 32'h0001_9FFC, 32'h0001_A000,
		32'h0002_0000, 32'h000E_00FC, 32'h0002_0100, 32'h000F_0000,
		32'hFFF7_EC00};
	// 25 MHz clock
	always #20 clk = ~clk;
	asu_address_select_unit asu_address_select_unit_i (.clk(clk), .srst(srst),
		.cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
		.cpu_wdata(cpu_wdata), .cpu_priv(cpu_priv), .cpu_wait(cpu_wait),
		.cpu_rdata(cpu_rdata), .sel(sel), .loc(loc), .unmapped(unmapped),
		.map_normal(map_normal));
	asu_cpu_model asu_cpu_model_i (.clk(clk), .cpu_req(cpu_req),
		.cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_wdata(cpu_wdata),
		.cpu_priv(cpu_priv), .cpu_wait(cpu_wait), .cpu_rdata(cpu_rdata));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	// expected selects from the two fixed maps
	function automatic asu_sel_t exp_sel(logic [31:0] a, logic nrm);
		asu_sel_t s;
		s = '0;
		s.own_regs = (a[31:8] == 24'hFF_FFFE);
		if (a[31:20] == 12'h000 && a[15:8] == 8'h00 && a[19:16] >= 4'h2
			&& a[19:16] <= 4'he) begin
			s.periph[a[19:16] - 4'h2] = 1'b1;
		end
		s.data_flash = (a >= 32'h0001_8800 && a <= 32'h0001_8FFF);
		s.data_ram = (a >= 32'h0001_9000 && a <= 32'h0001_9FFF);
		s.prog_flash = nrm ? (a <= 32'h0000_7FFF)
			: (a >= 32'h0001_0000 && a <= 32'h0001_7FFF);
		s.boot_rom = nrm ? (a >= 32'h0001_0000 && a <= 32'h0001_0FFF)
			: (a <= 32'h0000_FFFF);
		return s;
	endfunction : exp_sel
	// word index inside the selected memory; the ROM repeats every 4K
	function automatic logic [12:0] exp_word(asu_sel_t s, logic [31:0] a);
		logic [12:0] wd;
		wd = 13'h0000;
		if (s.boot_rom || s.data_ram) wd = {3'b000, a[11:2]};
		if (s.prog_flash) wd = a[14:2];
		if (s.data_flash) wd = {4'h0, a[10:2]};
		return wd;
	endfunction : exp_word
	task automatic end_sim();
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one access with decode, location and wait-state checks
	task automatic acc(logic [31:0] a, logic wr, logic [31:0] wd, logic pr,
		logic nrm);
		asu_sel_t e;
		e = exp_sel(a, nrm);
		asu_cpu_model_i.start(a, wr, wd, pr);
		#1;
		chk(32'(sel), 32'(e));
		chk(32'(unmapped), 32'(e == '0));
		chk(32'({loc.pf_page, loc.df_page}), 32'({a[14:10], a[10:5]}));
		chk(32'(loc.word_addr), 32'(exp_word(e, a)));
		asu_cpu_model_i.finish(rd, w);
		chk(32'(w), 32'(e.own_regs));
		if (w >= 8) begin
			fails++;
			end_sim();
		end
	endtask : acc
	// corners then random traffic, half of it in the low megabyte
	task automatic sweep(logic nrm);
		foreach (cor[i]) acc(cor[i], 1'b0, 32'h0, 1'b1, nrm);
		repeat (60) begin
			a = xs();
			if (a[31]) a = {12'h000, a[19:0]};
			acc(a, a[0], xs(), 1'b1, nrm);
		end
	endtask : sweep
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk) srst = 1'b0;
		chk(32'(map_normal), 32'h0);
		sweep(1'b0);
		acc(32'hFFFF_FE14, 1'b0, 32'h0, 1'b1, 1'b0);
		chk(rd, 32'h0000_0005);
		acc(32'hFFFF_FE20, 1'b0, 32'h0, 1'b1, 1'b0);
		chk(rd, 32'h0001_8800);
		acc(32'hFFFF_FE00, 1'b1, 32'h0000_0001, 1'b0, 1'b0);
		chk(32'(map_normal), 32'h0);
		acc(32'hFFFF_FE00, 1'b1, 32'h0000_0001, 1'b1, 1'b0);
		chk(32'(map_normal), 32'h1);
		sweep(1'b1);
		acc(32'hFFFF_FE00, 1'b0, 32'h0, 1'b1, 1'b1);
		chk(rd, 32'h0000_0001);
		// move the ram window and oversize it; clamp must stop at 16 MB
		acc(32'hFFFF_FE28, 1'b1, 32'h0100_0000, 1'b1, 1'b1);
		acc(32'hFFFF_FE2C, 1'b1, 32'h0000_000F, 1'b1, 1'b1);
		acc(32'hFFFF_FE2C, 1'b0, 32'h0, 1'b1, 1'b1);
		chk(rd, 32'h0000_000E);
		acc(32'hFFFF_FE28, 1'b0, 32'h0, 1'b1, 1'b1);
		chk(rd, 32'h0100_0000);
		asu_cpu_model_i.start(32'h01FF_FFFC, 1'b0, 32'h0, 1'b1);
		#1;
		chk(32'(sel.data_ram), 32'h1);
		asu_cpu_model_i.finish(rd, w);
		asu_cpu_model_i.idle();
		// second reset must bring the boot map back
		@(negedge clk) srst = 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk) srst = 1'b0;
		chk(32'(map_normal), 32'h0);
		acc(32'h0000_8004, 1'b0, 32'h0, 1'b1, 1'b0);
		asu_cpu_model_i.idle();
		end_sim();
	end
endmodule : tb_memory_map_decoder
